// >>> verilog/tvt_trigger.sv
// Purpose: decides when a process value is saved as an event
// Assumes: smp_valid/smp_value come from logic on ref_clk
// Notes: one data point; configuration is static while running
//
// How it works
// - preprocessing runs before the integrative threshold check only
// - binary, counter, mean analog use absolute band
// - plain analog uses integrated deviation
// - band is last saved value plus/minus threshold
// - save on reaching bound, rebuild band
// - integrative compare once per 500 ms cycle
// - sum signed deviations, fire at threshold magnitude
// - no trigger means no preprocessing
// - no trigger passes raw value at once
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module tvt_trigger #(
	parameter int CALC_CYC = tvt_pkg::CALC_CYCLES
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [tvt_pkg::ADDR_W-1:0] addr,
	input wire logic [tvt_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [tvt_pkg::DATA_W-1:0] rd_data,
	// process value source
	input wire logic smp_valid,
	input wire logic [tvt_pkg::VAL_W-1:0] smp_value,
	// send buffer
	output logic evt_valid,
	output logic [tvt_pkg::VAL_W-1:0] evt_value,
	// image memory
	output logic img_valid,
	output logic [tvt_pkg::VAL_W-1:0] img_value,
	// interrupt
	output logic irq
);
	import tvt_pkg::*;

	localparam int CNT_W = $clog2(CALC_CYC);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [VAL_W-1:0] thresh;
		logic [VAL_W-1:0] lim_lo;
		logic [VAL_W-1:0] lim_hi;
		logic [EVT_W-1:0] status;
		logic [EVT_W-1:0] mask;
		logic [DATA_W-1:0] rd_data;
		logic [VAL_W-1:0] saved;
		logic have_ref;
		logic [VAL_W-1:0] cur;
		logic cur_ok;
		logic [SUM_W-1:0] sum;
		logic [CNT_W-1:0] tick_cnt;
		logic evt_valid;
		logic [VAL_W-1:0] evt_value;
		logic img_valid;
		logic [VAL_W-1:0] img_value;
		logic irq;
	} tvt_state_s;

	tvt_state_s s_r;
	tvt_state_s s_nxt;
	tvt_mode_e mode;
	logic pp_en;
	logic pp_valid;
	logic [VAL_W-1:0] pp_value;
	logic tick;
	logic abs_hit;
	logic int_hit;
	logic ctrl_wr;
	logic [EVT_W-1:0] ev;
	logic [EVT_W-1:0] w1c;
	logic signed [VAL_W+1:0] band_hi;
	logic signed [VAL_W+1:0] band_lo;
	logic signed [VAL_W+1:0] pp_ext;
	logic signed [SUM_W-1:0] dev;
	logic signed [SUM_W-1:0] sum_add;
	logic signed [SUM_W-1:0] sum_mag;

	// ------------------------------------------------------------
	// preprocessing
	// ------------------------------------------------------------
	// only analog points with a trigger and no mean values are shaped
	assign mode = tvt_mode_of(s_r.ctrl);
	assign pp_en = (mode == TVT_MODE_INT);

	tvt_preproc u_pp (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.en(pp_en),
		.smooth_sel(s_r.ctrl[CTRL_SMOOTH_LSB +: 2]),
		.unipolar(s_r.ctrl[CTRL_UNIPOLAR]),
		.limit_en(s_r.ctrl[CTRL_LIMIT_EN]),
		.limit_lo(s_r.lim_lo),
		.limit_hi(s_r.lim_hi),
		.in_valid(smp_valid),
		.in_value(smp_value),
		.out_valid(pp_valid),
		.out_value(pp_value)
	);

	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	// two extra bits keep saved +/- threshold from wrapping
	always_comb begin
		pp_ext = (VAL_W+2)'($signed(pp_value));
		band_hi = (VAL_W+2)'($signed(s_r.saved)) + $signed({2'h0, s_r.thresh});
		band_lo = (VAL_W+2)'($signed(s_r.saved)) - $signed({2'h0, s_r.thresh});
		abs_hit = (pp_ext >= band_hi) || (pp_ext <= band_lo);
		dev = SUM_W'($signed(s_r.cur)) - SUM_W'($signed(s_r.saved));
		sum_add = $signed(s_r.sum) + dev;
		sum_mag = sum_add < 0 ? -sum_add : sum_add;
		int_hit = sum_mag >= $signed({{(SUM_W-VAL_W){1'b0}}, s_r.thresh});
		tick = (s_r.tick_cnt == CNT_W'(CALC_CYC - 1));
		ctrl_wr = wr_en && addr == ADDR_CTRL;
		w1c = (wr_en && addr == ADDR_STATUS) ? wr_data[EVT_W-1:0] : '0;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.evt_valid = 1'b0;
		s_nxt.img_valid = 1'b0;
		s_nxt.rd_data = '0;
		ev = '0;

		// free-running calculation tick
		s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + 1'b1;

		// register writes
		if (wr_en) begin
			case (addr)
				ADDR_CTRL: s_nxt.ctrl = wr_data[CTRL_W-1:0];
				ADDR_THRESH: s_nxt.thresh = wr_data[VAL_W-1:0];
				ADDR_LIMIT: begin
					s_nxt.lim_lo = wr_data[VAL_W-1:0];
					s_nxt.lim_hi = wr_data[LIMIT_HI_LSB +: VAL_W];
				end
				ADDR_MASK: s_nxt.mask = wr_data[EVT_W-1:0];
				default: ;
			endcase
		end

		// register reads, data in the next cycle only
		if (rd_en) begin
			case (addr)
				ADDR_CTRL: s_nxt.rd_data = DATA_W'(s_r.ctrl);
				ADDR_THRESH: s_nxt.rd_data = DATA_W'(s_r.thresh);
				ADDR_LIMIT: s_nxt.rd_data = {s_r.lim_hi, s_r.lim_lo};
				ADDR_SAVED: s_nxt.rd_data = {{(DATA_W-VAL_W-1){1'b0}}, s_r.have_ref, s_r.saved};
				ADDR_SUM: s_nxt.rd_data = DATA_W'($signed(s_r.sum));
				ADDR_STATUS: s_nxt.rd_data = DATA_W'(s_r.status);
				ADDR_MASK: s_nxt.rd_data = DATA_W'(s_r.mask);
				default: s_nxt.rd_data = '0;
			endcase
		end

		// evaluation per method
		case (mode)
			TVT_MODE_BYPASS: begin
				// raw value straight to the image, no event, no 500 ms wait
				if (smp_valid) begin
					s_nxt.img_valid = 1'b1;
					s_nxt.img_value = smp_value;
					ev[ST_RAW] = 1'b1;
				end
			end
			TVT_MODE_ABS: begin
				// the first value after enabling is the reference
				if (pp_valid && (!s_r.have_ref || abs_hit)) begin
					s_nxt.saved = pp_value;
					s_nxt.have_ref = 1'b1;
					s_nxt.evt_valid = 1'b1;
					s_nxt.evt_value = pp_value;
					s_nxt.img_valid = 1'b1;
					s_nxt.img_value = pp_value;
					ev[ST_ABS] = 1'b1;
				end
			end
			TVT_MODE_INT: begin
				if (pp_valid) begin
					s_nxt.cur = pp_value;
					s_nxt.cur_ok = 1'b1;
				end
				if (pp_valid && !s_r.have_ref) begin
					s_nxt.saved = pp_value;
					s_nxt.have_ref = 1'b1;
					s_nxt.sum = '0;
					s_nxt.evt_valid = 1'b1;
					s_nxt.evt_value = pp_value;
					s_nxt.img_valid = 1'b1;
					s_nxt.img_value = pp_value;
					ev[ST_INT] = 1'b1;
				end else if (tick && s_r.cur_ok && s_r.have_ref) begin
					if (int_hit) begin
						s_nxt.saved = s_r.cur;
						s_nxt.sum = '0;
						s_nxt.evt_valid = 1'b1;
						s_nxt.evt_value = s_r.cur;
						s_nxt.img_valid = 1'b1;
						s_nxt.img_value = s_r.cur;
						ev[ST_INT] = 1'b1;
					end else begin
						s_nxt.sum = sum_add;
					end
				end
			end
			default: ;
		endcase

		// a new method starts from a fresh reference
		if (ctrl_wr) begin
			s_nxt.have_ref = 1'b0;
			s_nxt.cur_ok = 1'b0;
			s_nxt.sum = '0;
		end

		// sticky status: a new event beats a same-cycle clear
		s_nxt.status = (s_r.status & ~w1c) | ev;
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.ctrl <= CTRL_RST;
			s_r.thresh <= THRESH_RST;
			s_r.lim_lo <= LIMIT_LO_RST;
			s_r.lim_hi <= LIMIT_HI_RST;
			s_r.mask <= MASK_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign rd_data = s_r.rd_data;
	assign evt_valid = s_r.evt_valid;
	assign evt_value = s_r.evt_value;
	assign img_valid = s_r.img_valid;
	assign img_value = s_r.img_value;
	assign irq = s_r.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_raw_passthrough: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_BYPASS && smp_valid |=> img_valid && img_value == $past(smp_value))
		else $error("raw value not passed to image");

	chk_bypass_no_event: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_BYPASS && !ctrl_wr |=> !evt_valid && !$changed(s_r.saved))
		else $error("event or save without trigger");

	chk_pp_first_ref: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_ABS && pp_valid && !s_r.have_ref && !ctrl_wr
		|=> evt_valid && evt_value == $past(pp_value))
		else $error("reference not taken from preprocessed value");

	chk_abs_band_save: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_ABS && pp_valid && s_r.have_ref && abs_hit && !ctrl_wr
		|=> evt_valid && s_r.saved == $past(pp_value) && s_r.status[ST_ABS])
		else $error("band bound reached but value not saved");

	chk_abs_band_hold: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_ABS && s_r.have_ref && !(pp_valid && abs_hit) && !ctrl_wr
		|=> !evt_valid && s_r.saved == $past(s_r.saved))
		else $error("save inside band");

	chk_int_tick_only: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_INT && s_r.have_ref && !tick && !ctrl_wr |=> !evt_valid ##0 $stable(s_r.sum))
		else $error("integrative step off the calculation tick");

	chk_int_fire_clear: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_INT && tick && s_r.cur_ok && s_r.have_ref && int_hit && !ctrl_wr
		|=> evt_valid && s_r.sum == '0 && s_r.saved == $past(s_r.cur))
		else $error("integrative fire did not clear and rebase");

	chk_int_accumulate: assert property (@(posedge ref_clk) disable iff (rst)
		ce && mode == TVT_MODE_INT && tick && s_r.cur_ok && s_r.have_ref && !int_hit && !ctrl_wr
		|=> !evt_valid && $signed(s_r.sum) == $past(sum_add))
		else $error("deviation not added to running sum");

	chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
		ce && tick |=> s_r.tick_cnt == '0 || !$past(ce))
		else $error("calculation counter did not wrap");

	chk_mode_select: assert property (@(posedge ref_clk) disable iff (rst)
		s_r.ctrl[CTRL_TRIG_EN] && (s_r.ctrl[CTRL_MEAN_EN] || s_r.ctrl[CTRL_KIND_LSB +: 2] != 2'h2)
		|-> mode == TVT_MODE_ABS)
		else $error("wrong method for absolute point");

endmodule : tvt_trigger

// >>> verilog/tvt_pkg.sv
// Purpose: shared constants and types of the threshold value trigger
// Assumes: one data point per instance, 50 MHz ref_clk
// Notes: register indices are word addresses on the plain register port
package tvt_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CALC_PERIOD_MS = 500;
	// calculation cycle in ref_clk periods
	localparam int CALC_CYCLES = CALC_PERIOD_MS * (CLK_HZ / 1000);

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int VAL_W = 16;
	localparam int SUM_W = 24;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int EVT_W = 3;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_THRESH = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_SAVED = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_SUM = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h6;

	// control fields
	localparam int CTRL_W = 8;
	localparam int CTRL_TRIG_EN = 0;
	localparam int CTRL_MEAN_EN = 1;
	localparam int CTRL_KIND_LSB = 2;
	localparam int CTRL_SMOOTH_LSB = 4;
	localparam int CTRL_UNIPOLAR = 6;
	localparam int CTRL_LIMIT_EN = 7;
	localparam int LIMIT_HI_LSB = 16;

	// status and mask bits
	localparam int ST_ABS = 0;
	localparam int ST_INT = 1;
	localparam int ST_RAW = 2;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [VAL_W-1:0] THRESH_RST = 16'h0001;
	localparam logic [VAL_W-1:0] LIMIT_LO_RST = 16'h8000;
	localparam logic [VAL_W-1:0] LIMIT_HI_RST = 16'h7FFF;
	localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

	// smoothing factor k = 1, 4, 32, 64 as right shifts
	localparam logic [2:0] SMOOTH_SH_1 = 3'h0;
	localparam logic [2:0] SMOOTH_SH_4 = 3'h2;
	localparam logic [2:0] SMOOTH_SH_32 = 3'h5;
	localparam logic [2:0] SMOOTH_SH_64 = 3'h6;

	typedef enum logic [1:0] {TVT_KIND_BINARY, TVT_KIND_COUNTER, TVT_KIND_ANALOG, TVT_KIND_SPARE} tvt_kind_e;
	typedef enum logic [1:0] {TVT_MODE_BYPASS, TVT_MODE_ABS, TVT_MODE_INT} tvt_mode_e;

	// evaluation method from the static control word
	function automatic tvt_mode_e tvt_mode_of(input logic [CTRL_W-1:0] ctrl);
		tvt_kind_e kind;
		kind = tvt_kind_e'(ctrl[CTRL_KIND_LSB +: 2]);
		if (!ctrl[CTRL_TRIG_EN])
			tvt_mode_of = TVT_MODE_BYPASS;
		else if (kind == TVT_KIND_ANALOG && !ctrl[CTRL_MEAN_EN])
			tvt_mode_of = TVT_MODE_INT;
		else
			tvt_mode_of = TVT_MODE_ABS;
	endfunction : tvt_mode_of

endpackage : tvt_pkg

// >>> verilog/tvt_preproc.sv
// Purpose: analog preprocessing ahead of the threshold check
// Assumes: in_valid is a one-cycle strobe on ref_clk
// Notes: smoothing, unipolar correction and limit clamp; one cycle latency
`timescale 1ns/1ps
module tvt_preproc (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// static configuration
	input wire logic en,
	input wire logic [1:0] smooth_sel,
	input wire logic unipolar,
	input wire logic limit_en,
	input wire logic [tvt_pkg::VAL_W-1:0] limit_lo,
	input wire logic [tvt_pkg::VAL_W-1:0] limit_hi,
	// sample in
	input wire logic in_valid,
	input wire logic [tvt_pkg::VAL_W-1:0] in_value,
	// preprocessed sample out
	output logic out_valid,
	output logic [tvt_pkg::VAL_W-1:0] out_value
);
	import tvt_pkg::*;

	typedef struct packed {
		logic valid;
		logic [VAL_W-1:0] value;
		logic [VAL_W-1:0] smooth;
		logic primed;
	} tvt_pp_s;

	tvt_pp_s s_r;
	tvt_pp_s s_nxt;
	logic [2:0] sh;
	logic signed [VAL_W:0] step;
	logic signed [VAL_W-1:0] y;

	// y = y + (x - y) / k, the usual first-order smoothing
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = 1'b0;
		case (smooth_sel)
			2'h1: sh = SMOOTH_SH_4;
			2'h2: sh = SMOOTH_SH_32;
			2'h3: sh = SMOOTH_SH_64;
			default: sh = SMOOTH_SH_1;
		endcase
		step = ($signed({in_value[VAL_W-1], in_value}) - $signed({s_r.smooth[VAL_W-1], s_r.smooth})) >>> sh;
		y = $signed(in_value);
		if (en && s_r.primed)
			y = VAL_W'($signed({s_r.smooth[VAL_W-1], s_r.smooth}) + step);
		if (en && unipolar && y < 0)
			y = '0;
		if (en && limit_en && y < $signed(limit_lo))
			y = $signed(limit_lo);
		if (en && limit_en && y > $signed(limit_hi))
			y = $signed(limit_hi);
		if (in_valid) begin
			s_nxt.valid = 1'b1;
			s_nxt.value = y;
			s_nxt.smooth = y;
			s_nxt.primed = en;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign out_valid = s_r.valid;
	assign out_value = s_r.value;

endmodule : tvt_preproc

// >>> bench/tvt_src_model.sv
// Purpose: process value source and send buffer beside the trigger
// Assumes: one sample pulse at a time, driven after a rising edge
// Notes: the value line is scrambled once its pulse is over
`timescale 1ns/1ps
module tvt_src_model (
	// clock
	input wire logic ref_clk,
	// process value out
	output logic smp_valid,
	output logic [tvt_pkg::VAL_W-1:0] smp_value,
	// send buffer in
	input wire logic evt_valid,
	input wire logic [tvt_pkg::VAL_W-1:0] evt_value
);
	import tvt_pkg::*;

	// ------------------------------------------------------------
	// source side
	// ------------------------------------------------------------
	int evt_cnt;
	logic [VAL_W-1:0] last_evt;

	initial begin
		smp_valid = 1'b0;
		smp_value = 16'h0000;
		evt_cnt = 0;
		last_evt = 16'h0000;
	end

	// one-cycle pulse; inverted value after it so a stale read shows up
	task send(input logic [VAL_W-1:0] v);
		@(posedge ref_clk);
		smp_valid <= 1'b1;
		smp_value <= v;
		@(posedge ref_clk);
		smp_valid <= 1'b0;
		smp_value <= ~v;
	endtask : send

	// ------------------------------------------------------------
	// send buffer side
	// ------------------------------------------------------------
	// counts every entered value, only the count and last kept
	always @(posedge ref_clk) begin
		if (evt_valid === 1'b1) begin
			evt_cnt <= evt_cnt + 1;
			last_evt <= evt_value;
		end
	end
endmodule : tvt_src_model

// >>> bench/tb.sv
// Purpose: self-checking bench of the threshold value trigger
// Assumes: short calculation cycle of 20 clocks
// Notes: registers via the plain port; ce dropped once to freeze the block
`timescale 1ns/1ps
module tb;
	import tvt_pkg::*;

	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	localparam int CYC = 20;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rd_data;
	logic smp_valid, evt_valid, img_valid, irq;
	logic [VAL_W-1:0] smp_value, evt_value, img_value;
	int mismatches = 0;
	int n_compared = 0;

	tvt_trigger #(.CALC_CYC(CYC)) dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .smp_valid(smp_valid),
		.smp_value(smp_value), .evt_valid(evt_valid), .evt_value(evt_value), .img_valid(img_valid),
		.img_value(img_value), .irq(irq));
	tvt_src_model src (.ref_clk(ref_clk), .smp_valid(smp_valid), .smp_value(smp_value),
		.evt_valid(evt_valid), .evt_value(evt_value));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr

	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, exp, "read data");
	endtask : rd

	// one sample; a save shows one cycle after the taking edge
	task sev(input logic [VAL_W-1:0] v, input int fire);
		int n;
		n = src.evt_cnt;
		src.send(v);
		@(posedge ref_clk);
		#1;
		if (fire != 0) begin
			chk(evt_valid, 1'b1, "event pulse");
			chk(evt_value, v, "event value");
			chk(img_value, v, "image value");
		end
		repeat (2) @(posedge ref_clk);
		#1;
		chk(src.evt_cnt, n + fire, "event count");
		if (fire != 0)
			chk(src.last_evt, v, "buffer value");
	endtask : sev

	task w_evt(input int lim, input logic [VAL_W-1:0] exp);
		int i;
		// step off the edge so a pulse launched there is not missed
		#1;
		for (i = 0; i < lim && evt_valid !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk(evt_valid, 1'b1, "integrated save");
		chk(evt_value, exp, "integrated value");
	endtask : w_evt

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_THRESH, 32'h1);
		rd(ADDR_LIMIT, 32'h7FFF8000);
		rd(ADDR_MASK, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		rd(4'hF, 32'h0);
	endtask : t_reset

	// no trigger: raw value into the image one cycle on, masked status bit
	task t_bypass;
		wr(ADDR_MASK, 32'h1);
		src.send(16'h8123);
		#1;
		chk(img_valid, 1'b1, "image pulse");
		chk(img_value, 16'h8123, "raw image");
		repeat (3) @(posedge ref_clk);
		chk(src.evt_cnt, 0, "no event");
		rd(ADDR_STATUS, 32'h4);
		chk(irq, 1'b0, "masked irq");
		wr(ADDR_STATUS, 32'h4);
		// a sample offered while ce is low must be lost, image untouched
		ce <= 1'b0;
		src.send(16'h0042);
		repeat (2) @(posedge ref_clk);
		ce <= 1'b1;
		#1;
		chk(img_value, 16'h8123, "frozen image");
		rd(ADDR_STATUS, 32'h0);
	endtask : t_bypass

	// band around last save, both bounds, for binary and counter kinds
	task t_abs;
		int k;
		for (k = 0; k < 2; k++) begin
			wr(ADDR_CTRL, 32'(k * 4 + 1));
			wr(ADDR_THRESH, 32'h5);
			sev(16'h0064, 1);
			sev(16'h0068, 0);
			sev(16'h0069, 1);
			sev(16'h0065, 0);
			sev(16'h0064, 1);
			chk(irq, 1'b1, "irq raised");
			rd(ADDR_STATUS, 32'h1);
			wr(ADDR_STATUS, 32'h7);
			repeat (2) @(posedge ref_clk);
			chk(irq, 1'b0, "irq cleared");
		end
	endtask : t_abs

	// clamped analog value integrated per calculation cycle, both signs
	task t_int;
		int n;
		wr(ADDR_LIMIT, 32'h00CD00BE);
		wr(ADDR_THRESH, 32'h14);
		wr(ADDR_CTRL, 32'h89);
		sev(16'h00C8, 1);
		src.send(16'h00FA);
		n = src.evt_cnt;
		repeat (50) @(posedge ref_clk);
		chk(src.evt_cnt, n, "no early save");
		w_evt(60, 16'h00CD);
		rd(ADDR_SUM, 32'h0);
		rd(ADDR_SAVED, 32'h000100CD);
		src.send(16'h0064);
		w_evt(3 * CYC, 16'h00BE);
	endtask : t_int

	// ------------------------------------------------------------
	// sequence and verdict
	// ------------------------------------------------------------
	task summarize;
		$display("mismatches %0d n_compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_bypass;
		t_abs;
		t_int;
		summarize;
	end

	// the whole run needs about 300 clocks
	initial begin
		#(20 * 20000);
		mismatches++;
		summarize;
	end
endmodule : tb
